/* rtl/spf_fifo.sv */
`timescale 1ns/100ps
// Receive buffer with honest full and empty flags
module spf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    spf_stream_if.store s
);
    import spf_pkg::*;
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // Storage words
    logic [PW-1:0] wr_ptr; // Next word to fill
    logic [PW-1:0] rd_ptr; // Next word to drain
    logic [PW:0] count; // Words held

    ////////////////////////////////////////////////////////////////////
    // Flags and strobes
    wire full = (count == (PW+1)'(DEPTH));
    wire empty = (count == '0);
    wire do_push = s.in_valid && !full;
    wire do_pop = s.out_ready && !empty;
    assign s.in_ready = !full;
    assign s.out_valid = !empty;
    assign s.out_data = mem[rd_ptr];

    ////////////////////////////////////////////////////////////////////
    // Storage write, no reset needed on the data words
    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= s.in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= PW'(wr_ptr + 1'b1);
            end
            if (do_pop) begin
                rd_ptr <= PW'(rd_ptr + 1'b1);
            end
            // Push and pop together leave the count unchanged
            count <= (PW+1)'(count + do_push - do_pop);
        end
    end
endmodule : spf_fifo

/* rtl/spf_host.sv */
`timescale 1ns/100ps
module spf_host #(
    parameter int SCL_HALF = spf_pkg::SCL_HALF_DEF,
    parameter int RXBUF_DEPTH = spf_pkg::RXBUF_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // User request port
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire spf_pkg::spf_kind_t i_req_kind,
    input wire logic [spf_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [spf_pkg::DATA_W-1:0] i_req_wdata,
    // Read results
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [spf_pkg::DATA_W-1:0] o_rd_data,
    output logic o_busy,
    // Device pins
    output logic o_scl,
    output logic o_register_select_n,
    output logic o_fifo_select_n,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    input wire logic i_sda_in,
    input wire logic i_fifo_not_empty_irq,
    input wire logic i_fifo_threshold_irq,
    input wire logic i_fifo_byte_written_irq,
    input wire logic i_fifo_overflow_irq,
    // Filtered device interrupt levels
    output logic o_fifo_not_empty,
    output logic o_fifo_threshold,
    output logic o_fifo_byte_written,
    output logic o_fifo_overflow
);
    import spf_pkg::*;

    // Phase lengths, counted down to zero
    localparam logic [CNT_W-1:0] HALF_LD = CNT_W'(SCL_HALF - 1);
    // FIFO select setup lasts two halves, so with the low half it leads the first rise by three
    localparam logic [CNT_W-1:0] FSETUP_LD = CNT_W'(2 * SCL_HALF - 1);
    // FIFO hold and gap, rounded up to whole cycles
    localparam logic [CNT_W-1:0] FHOLD_LD = CNT_W'(FIFO_HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] FGAP_LD = CNT_W'(FIFO_GAP_CYC - 1);

    ////////////////////////////////////////////////////////////////////
    // Input synchroniser: three flops, a change counts when the last
    // two agree, so a single metastable sample never reaches the logic
    wire [SYNC_N-1:0] pin_raw;
    logic [SYNC_N-1:0] pin_s1; // First stage, read only by the second
    logic [SYNC_N-1:0] pin_s2;
    logic [SYNC_N-1:0] pin_s3;
    logic [SYNC_N-1:0] pin_f; // Filtered levels

    assign pin_raw = {i_fifo_overflow_irq, i_fifo_byte_written_irq,
                      i_fifo_threshold_irq, i_fifo_not_empty_irq,
                      i_sda_in};

    genvar g;
    generate
        for (g = 0; g < SYNC_N; g++) begin : g_sync
            // Shift chain and agreement filter per pin
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    pin_s1[g] <= 1'b0;
                    pin_s2[g] <= 1'b0;
                    pin_s3[g] <= 1'b0;
                    pin_f[g] <= 1'b0;
                end else begin
                    pin_s1[g] <= pin_raw[g];
                    pin_s2[g] <= pin_s1[g];
                    pin_s3[g] <= pin_s2[g];

                    // Keep the old level while the stages disagree
                    if (pin_s2[g] == pin_s3[g]) begin
                        pin_f[g] <= pin_s3[g];
                    end
                end
            end
        end
    endgenerate

    // The device clears these by itself; the host only mirrors them
    assign o_fifo_not_empty = pin_f[PIN_NMTY];
    assign o_fifo_threshold = pin_f[PIN_TH];
    assign o_fifo_byte_written = pin_f[PIN_WBYTE];
    assign o_fifo_overflow = pin_f[PIN_OVF];
    // Data line level, three or four cycles old
    wire sda_f = pin_f[PIN_SDA];

    ////////////////////////////////////////////////////////////////////
    // Sequencer state
    spf_state_t state, next_state;
    spf_kind_t kind, next_kind; // Transfer in flight

    logic [CNT_W-1:0] cnt, next_cnt; // Phase counter
    logic [BIT_W-1:0] bit_n, next_bit_n; // Bits finished so far
    logic [FRAME_W-1:0] tx, next_tx; // Outgoing bits, MSB on the line
    logic [DATA_W-1:0] rx, next_rx; // Incoming bits

    // Pin copies, each one a flop
    logic scl, next_scl;
    logic reg_sel_n, next_reg_sel_n;
    logic fifo_sel_n, next_fifo_sel_n;
    logic sda_out, next_sda_out;
    logic sda_oe_n, next_sda_oe_n;

    logic push, next_push; // One-cycle offer to the buffer

    // Receive buffer
    spf_stream_if #(.WIDTH(DATA_W)) rxs ();

    spf_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(RXBUF_DEPTH)
    ) u_rxbuf (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .s(rxs)
    );

    // Buffer hookup; a full buffer holds off new requests
    assign rxs.in_valid = push;
    assign rxs.in_data = rx;
    assign rxs.out_ready = i_rd_ready;
    assign o_rd_valid = rxs.out_valid;
    assign o_rd_data = rxs.out_data;

    ////////////////////////////////////////////////////////////////////
    // Decoding of the transfer kind
    wire is_fifo = (kind == SPF_KIND_FIFO);
    wire is_read = (kind != SPF_KIND_WRITE);

    // Total bits: register frames carry a data byte after the address
    wire [BIT_W-1:0] last_bits = is_fifo ? FIFO_BITS : REG_BITS;

    // Bits the host itself drives; a read turns the line around
    wire [BIT_W-1:0] drive_bits = (kind == SPF_KIND_WRITE) ? REG_BITS :
        (kind == SPF_KIND_READ) ? HEAD_BITS : NO_BITS;

    // Bits the device drives are the last data byte of the frame
    wire sample_now = is_read && (bit_n >= BIT_W'(last_bits - FIFO_BITS));

    // Bit position arithmetic
    wire [BIT_W-1:0] bit_inc = BIT_W'(bit_n + 1'b1);
    wire frame_end = (bit_inc == last_bits);
    wire drive_next = (bit_inc < drive_bits);
    wire drive_first = (NO_BITS < drive_bits);
    wire cnt_zero = (cnt == '0);

    // A read needs buffer room so its byte can never be lost
    wire idle = (state == SPF_IDLE);
    assign o_req_ready = idle && rxs.in_ready;
    wire req_fire = i_req_valid && o_req_ready;
    wire req_fifo = (i_req_kind == SPF_KIND_FIFO);
    wire req_rw = (i_req_kind == SPF_KIND_WRITE) ? RW_WRITE : RW_READ;

    // Direction bit, then address, then data, highest bit first
    wire [FRAME_W-1:0] req_frame = req_fifo ? '0 :
        {req_rw, i_req_addr, i_req_wdata};

    // Pin outputs
    assign o_busy = !idle;
    assign o_scl = scl;
    assign o_register_select_n = reg_sel_n;
    assign o_fifo_select_n = fifo_sel_n;
    assign o_sda_out = sda_out;
    assign o_sda_oe_n = sda_oe_n;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic of the link sequencer
    always_comb begin
        // Every register except push holds unless a branch moves it; push drops to zero
        next_state = state;
        next_kind = kind;
        next_cnt = cnt;
        next_bit_n = bit_n;
        next_tx = tx;
        next_rx = rx;
        next_scl = scl;
        next_reg_sel_n = reg_sel_n;
        next_fifo_sel_n = fifo_sel_n;
        next_sda_out = sda_out;
        next_sda_oe_n = sda_oe_n;
        next_push = 1'b0;

        case (state)
            SPF_IDLE: begin
                // Take a request and lower exactly one select
                if (req_fire) begin
                    next_state = SPF_SETUP;
                    next_kind = i_req_kind;
                    next_tx = req_frame;
                    next_bit_n = '0;
                    next_rx = '0;
                    // Only one select ever goes low
                    next_reg_sel_n = req_fifo;
                    next_fifo_sel_n = !req_fifo;
                    // FIFO select leads the first rise by a period and a half
                    next_cnt = req_fifo ? FSETUP_LD : HALF_LD;
                end
            end

            SPF_SETUP: begin
                // Select settled; the first bit goes out with clock low
                if (cnt_zero) begin
                    next_state = SPF_LOW;
                    next_cnt = HALF_LD;
                    next_sda_out = tx[FRAME_W-1];
                    next_sda_oe_n = !drive_first;
                end else begin
                    next_cnt = CNT_W'(cnt - 1'b1);
                end
            end

            SPF_LOW: begin
                // Rising edge: capture what the device drives
                if (cnt_zero) begin
                    next_state = SPF_HIGH;
                    next_cnt = HALF_LD;
                    next_scl = 1'b1;
                    if (sample_now) begin
                        next_rx = {rx[DATA_W-2:0], sda_f};
                    end
                end else begin
                    next_cnt = CNT_W'(cnt - 1'b1);
                end
            end

            SPF_HIGH: begin
                // Falling edge: the next bit changes only here
                if (cnt_zero) begin
                    next_scl = 1'b0;
                    next_bit_n = bit_inc;
                    next_tx = {tx[FRAME_W-2:0], 1'b0};
                    if (frame_end) begin
                        next_state = SPF_HOLD;
                        next_sda_oe_n = 1'b1;
                        // FIFO select stays low 2 us past the last fall
                        next_cnt = is_fifo ? FHOLD_LD : HALF_LD;
                    end else begin
                        next_state = SPF_LOW;
                        next_cnt = HALF_LD;
                        next_sda_out = tx[FRAME_W-2];
                        // Release the line at the turnaround
                        next_sda_oe_n = !drive_next;
                    end
                end else begin
                    next_cnt = CNT_W'(cnt - 1'b1);
                end
            end

            SPF_HOLD: begin
                // Raise the select and hand a read byte to the buffer
                if (cnt_zero) begin
                    next_state = SPF_GAP;
                    next_reg_sel_n = 1'b1;
                    next_fifo_sel_n = 1'b1;
                    next_push = is_read;
                    // The device advances its pointer per byte read, so
                    // every FIFO byte is its own framed transfer
                    next_cnt = is_fifo ? FGAP_LD : HALF_LD;
                end else begin
                    next_cnt = CNT_W'(cnt - 1'b1);
                end
            end

            SPF_GAP: begin
                // Both selects high; the device refreshes its flags
                if (cnt_zero) begin
                    next_state = SPF_IDLE;
                end else begin
                    next_cnt = CNT_W'(cnt - 1'b1);
                end
            end

            default: begin
                // Unreachable codes return to a safe idle
                next_state = SPF_IDLE;
                next_scl = 1'b0;
                next_reg_sel_n = 1'b1;
                next_fifo_sel_n = 1'b1;
                next_sda_oe_n = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer and pin registers
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state <= SPF_IDLE;
            kind <= SPF_KIND_WRITE;
            cnt <= '0;
            bit_n <= '0;
            tx <= '0;
            rx <= '0;
            push <= 1'b0;
        end else begin
            state <= next_state;
            kind <= next_kind;
            cnt <= next_cnt;
            bit_n <= next_bit_n;
            tx <= next_tx;
            rx <= next_rx;
            push <= next_push;
        end
    end

    // Pins come straight from flops, so no glitch reaches the device
    // Reset parks the link: clock low, selects high, data released
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            scl <= 1'b0;
            reg_sel_n <= 1'b1;
            fifo_sel_n <= 1'b1;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            scl <= next_scl;
            reg_sel_n <= next_reg_sel_n;
            fifo_sel_n <= next_fifo_sel_n;
            sda_out <= next_sda_out;
            sda_oe_n <= next_sda_oe_n;
        end
    end
endmodule : spf_host

/* rtl/spf_pkg.sv */
// Shared constants and types of the serial port controller
package spf_pkg;
    // System clock
    localparam int CLK_PERIOD_NS = 25; // 40 MHz system clock
    // Link timing, in nanoseconds as specified
    localparam int FIFO_HOLD_NS = 2000; // Select low after last falling edge
    localparam int FIFO_GAP_NS = 4000; // Select high between two FIFO bytes
    // Least times round up to whole cycles
    localparam int FIFO_HOLD_CYC = (FIFO_HOLD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int FIFO_GAP_CYC = (FIFO_GAP_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Default half period of the serial clock, in system cycles
    localparam int SCL_HALF_DEF = 20;
    // Width of the phase counter
    localparam int CNT_W = 8;
    // Frame layout
    localparam int ADDR_W = 7; // Register address
    localparam int DATA_W = 8; // One data byte
    localparam int FRAME_W = 16; // Direction bit, address, data
    localparam int BIT_W = 5; // Bit counter width
    localparam logic [BIT_W-1:0] REG_BITS = 5'h10; // Register frame length
    localparam logic [BIT_W-1:0] HEAD_BITS = 5'h08; // Direction plus address
    localparam logic [BIT_W-1:0] FIFO_BITS = 5'h08; // One FIFO byte
    localparam logic [BIT_W-1:0] NO_BITS = 5'h00; // Host drives nothing
    // Direction bit values
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;
    // Receive buffer shape
    localparam int RXBUF_DEPTH = 16;
    // Number of pins that pass the input synchroniser
    localparam int SYNC_N = 5;
    // Index of each synchronised pin
    localparam int PIN_SDA = 0;
    localparam int PIN_NMTY = 1;
    localparam int PIN_TH = 2;
    localparam int PIN_WBYTE = 3;
    localparam int PIN_OVF = 4;

    // Kinds of transfer the user may request
    typedef enum logic [1:0] {
        SPF_KIND_WRITE,
        SPF_KIND_READ,
        SPF_KIND_FIFO
    } spf_kind_t;

    // Link sequencer states
    typedef enum logic [2:0] {
        SPF_IDLE,
        SPF_SETUP,
        SPF_LOW,
        SPF_HIGH,
        SPF_HOLD,
        SPF_GAP
    } spf_state_t;
endpackage : spf_pkg

/* rtl/spf_stream_if.sv */
`timescale 1ns/100ps
// Byte stream between the sequencer and its receive buffer
interface spf_stream_if #(parameter int WIDTH = 8);
    logic in_valid; // Sequencer offers a byte
    logic in_ready; // Buffer has room
    logic [WIDTH-1:0] in_data;
    logic out_valid; // Buffer holds a byte
    logic out_ready; // User takes the byte
    logic [WIDTH-1:0] out_data;
    // Sequencer side
    modport ctrl (
        output in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data
    );
    // Buffer side
    modport store (
        input in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data
    );
endinterface : spf_stream_if

/* test/spf_dev_model.sv */
`timescale 1ns/100ps
// Behavioural receiver port: control registers and a 32-byte FIFO
module spf_dev_model #(
    parameter int TH = 8 // Threshold level chosen for the bench
) (
    input wire logic i_scl,
    input wire logic i_register_select_n,
    input wire logic i_fifo_select_n,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_n,
    output logic o_fifo_not_empty_irq,
    output logic o_fifo_threshold_irq,
    output logic o_fifo_byte_written_irq,
    output logic o_fifo_overflow_irq
);
    logic [7:0] regs [128]; // Control registers
    logic [7:0] fifo [32]; // Receive store
    logic [4:0] rp = '0; // Read pointer, wraps at 32
    logic [4:0] wp = '0; // Write pointer
    int cnt = 0; // Bytes held
    int nb = 0; // Bits clocked in this frame
    logic [15:0] sh = '0; // Incoming bits
    logic [7:0] tx = '0; // Outgoing bits, top one on the line
    initial begin
        o_sda = 1'b1;
        o_sda_oe_n = 1'b1;
        o_fifo_byte_written_irq = 1'b0;
        o_fifo_overflow_irq = 1'b0;
    end
    // Level flags follow the fill at once, no clear needed
    assign o_fifo_not_empty_irq = cnt != 0;
    assign o_fifo_threshold_irq = cnt >= TH;
    ///////////////////////////////////////////////////////////////////////
    // FIFO byte must be on the line before the first rise
    always @(negedge i_register_select_n or negedge i_fifo_select_n) begin
        nb = 0;
        if (!i_fifo_select_n) begin
            tx = fifo[rp];
            o_sda_oe_n = 1'b0;
            o_sda = tx[7];
        end
    end
    // Capture on the rising edge; writes land after sixteen bits
    always @(posedge i_scl) begin
        sh = {sh[14:0], i_sda};
        nb++;
        if (!i_register_select_n && nb == 16 && !sh[15]) begin
            regs[sh[14:8]] = sh[7:0];
        end
    end
    // Launch on the falling edge; read data turns the line round
    always @(negedge i_scl) begin
        if (!i_register_select_n && nb == 8 && sh[7]) begin
            tx = regs[sh[6:0]];
            o_sda_oe_n = 1'b0;
        end else begin
            tx = {tx[6:0], 1'b1};
        end
        o_sda = tx[7];
        if (nb == 16 || (!i_fifo_select_n && nb == 8)) begin
            o_sda_oe_n = 1'b1;
        end
        if (!i_fifo_select_n && nb == 8) begin
            rp++;
            cnt--;
        end
    end
    // Status refreshed when the FIFO select rises
    always @(posedge i_fifo_select_n) begin
        o_sda_oe_n = 1'b1;
        o_fifo_byte_written_irq = 1'b0;
        if (cnt < 32) begin
            o_fifo_overflow_irq = 1'b0;
        end
    end
    // Radio side writes one byte; a full store flags overflow
    task load(input logic [7:0] b);
        if (cnt == 32) begin
            o_fifo_overflow_irq = 1'b1;
        end else begin
            fifo[wp] = b;
            wp++;
            cnt++;
            o_fifo_byte_written_irq = 1'b1;
        end
    endtask : load
endmodule : spf_dev_model

/* test/spf_host_assertions.sv */
`timescale 1ns/100ps
// Pin-level framing and timing watch on the host
module spf_host_assertions
    import spf_pkg::*;
#(
    parameter int SCL_HALF = SCL_HALF_DEF
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic o_scl,
    input wire logic o_register_select_n,
    input wire logic o_fifo_select_n,
    input wire logic o_sda_out,
    input wire logic o_sda_oe_n,
    input wire logic i_fifo_not_empty_irq,
    input wire logic o_fifo_not_empty
);
    logic scl_q; // Serial clock one cycle back
    logic [8:0] sel_age; // Cycles a select has been low
    logic [8:0] fall_age; // Cycles since scl fell
    logic [8:0] high_age; // Cycles the FIFO select has been high
    logic [4:0] rises; // Rising edges in this frame
    wire in_frame = !o_register_select_n || !o_fifo_select_n;
    wire scl_fell = scl_q && !o_scl;
    wire scl_rose = !scl_q && o_scl;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    ///////////////////////////////////////////////////////////////////////
    // Ages saturate, so a long idle spell never wraps into a false failure
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            scl_q <= 1'b0;
            sel_age <= '0;
            fall_age <= '1;
            high_age <= '1;
            rises <= '0;
        end else begin
            scl_q <= o_scl;
            sel_age <= in_frame ? sel_age + 9'(sel_age != '1) : '0;
            fall_age <= scl_fell ? 9'h001 : fall_age + 9'(fall_age != '1);
            high_age <= o_fifo_select_n ? high_age + 9'(high_age != '1) : '0;
            rises <= in_frame ? rises + 5'(scl_rose) : '0;
        end
    end
    ///////////////////////////////////////////////////////////////////////
    chk_sel_exclusive: assert property (
        o_register_select_n || o_fifo_select_n
    ) else $error("both selects low together");
    chk_sda_on_fall: assert property (
        !o_sda_oe_n && !$past(o_sda_oe_n) && $changed(o_sda_out) |-> $fell(o_scl)
    ) else $error("host data changed off a falling edge");
    chk_sel_lead: assert property (
        $rose(o_scl) |-> sel_age >= 2 * SCL_HALF
    ) else $error("select too late before rising edge");
    chk_reg_tail: assert property (
        $rose(o_register_select_n) |-> fall_age >= SCL_HALF
    ) else $error("register select released too early");
    chk_fifo_tail: assert property (
        $rose(o_fifo_select_n) |-> fall_age >= FIFO_HOLD_CYC
    ) else $error("FIFO select released too early");
    chk_fifo_gap: assert property (
        $fell(o_fifo_select_n) |-> high_age >= FIFO_GAP_CYC
    ) else $error("FIFO select gap too short");
    chk_reg_bits: assert property (
        $rose(o_register_select_n) |-> rises == 5'h10
    ) else $error("register frame not sixteen bits");
    chk_fifo_bits: assert property (
        $rose(o_fifo_select_n) |-> rises == 5'h08
    ) else $error("FIFO frame not eight bits");
    chk_fifo_listen: assert property (
        !o_fifo_select_n |-> o_sda_oe_n
    ) else $error("host drove data during FIFO read");
    chk_irq_follow: assert property (
        i_fifo_not_empty_irq [*6] |-> o_fifo_not_empty
    ) else $error("filtered not-empty lags its pin");
endmodule : spf_host_assertions

bind spf_host spf_host_assertions #(.SCL_HALF(SCL_HALF)) spf_host_assertions_i (
    .i_clk, .i_sys_rst, .o_scl, .o_register_select_n, .o_fifo_select_n,
    .o_sda_out, .o_sda_oe_n, .i_fifo_not_empty_irq, .o_fifo_not_empty
);

/* test/tb.sv */
`timescale 1ns/100ps
// Self-checking bench for the serial port host
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    fails++; $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
    import spf_pkg::*;
    int fails = 0;
    int num_checks = 0;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_req_valid = 1'b0;
    spf_kind_t i_req_kind = SPF_KIND_WRITE;
    logic [6:0] i_req_addr = '0;
    logic [7:0] i_req_wdata = '0;
    logic i_rd_ready = 1'b0;
    logic o_req_ready, o_rd_valid, o_busy, o_scl, o_register_select_n;
    logic o_fifo_select_n, o_sda_out, o_sda_oe_n, dev_sda, dev_oe_n;
    logic [7:0] o_rd_data;
    logic i_fifo_not_empty_irq, i_fifo_threshold_irq;
    logic i_fifo_byte_written_irq, i_fifo_overflow_irq;
    logic o_fifo_not_empty, o_fifo_threshold;
    logic o_fifo_byte_written, o_fifo_overflow;
    logic [6:0] ta [3] = '{7'h00, 7'h7F, 7'h2A}; // Edge addresses and one mid-range
    logic [7:0] td [3] = '{8'hA5, 8'h3C, 8'h81};
    // Data line with a pull-up when nobody drives it
    wire sda_wire = !o_sda_oe_n ? o_sda_out : (!dev_oe_n ? dev_sda : 1'b1);
    ///////////////////////////////////////////////////////////////////////
    spf_host #(.SCL_HALF(5), .RXBUF_DEPTH(16)) spf_host_i (
        .i_clk, .i_sys_rst, .i_req_valid, .o_req_ready, .i_req_kind,
        .i_req_addr, .i_req_wdata, .o_rd_valid, .i_rd_ready, .o_rd_data,
        .o_busy, .o_scl, .o_register_select_n, .o_fifo_select_n,
        .o_sda_out, .o_sda_oe_n, .i_sda_in(sda_wire),
        .i_fifo_not_empty_irq, .i_fifo_threshold_irq,
        .i_fifo_byte_written_irq, .i_fifo_overflow_irq, .o_fifo_not_empty,
        .o_fifo_threshold, .o_fifo_byte_written, .o_fifo_overflow
    );
    spf_dev_model #(.TH(8)) spf_dev_model_i (
        .i_scl(o_scl), .i_register_select_n(o_register_select_n),
        .i_fifo_select_n(o_fifo_select_n), .i_sda(sda_wire),
        .o_sda(dev_sda), .o_sda_oe_n(dev_oe_n),
        .o_fifo_not_empty_irq(i_fifo_not_empty_irq),
        .o_fifo_threshold_irq(i_fifo_threshold_irq),
        .o_fifo_byte_written_irq(i_fifo_byte_written_irq),
        .o_fifo_overflow_irq(i_fifo_overflow_irq)
    );
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    ///////////////////////////////////////////////////////////////////////
    // One request: hold it until taken, then wait for idle
    task automatic req(input spf_kind_t k, input logic [6:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_req_valid <= 1'b1;
        i_req_kind <= k;
        i_req_addr <= a;
        i_req_wdata <= d;
        @(negedge i_clk);
        while (o_req_ready !== 1'b1 && n < 2000) begin
            n++;
            @(negedge i_clk);
        end
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        @(negedge i_clk);
        `CHK(o_busy, 1'b1)
        while (o_busy !== 1'b0 && n < 4000) begin
            n++;
            @(negedge i_clk);
        end
        `CHK(o_busy, 1'b0)
    endtask : req
    // Check the head byte, then take it
    task automatic pop(input logic [7:0] e);
        @(negedge i_clk);
        `CHK(o_rd_valid, 1'b1)
        `CHK(o_rd_data, e)
        @(posedge i_clk);
        i_rd_ready <= 1'b1;
        @(posedge i_clk);
        i_rd_ready <= 1'b0;
    endtask : pop
    // Back-to-back writes to edge and mid-range addresses, then read back
    task automatic t_reg();
        for (int i = 0; i < 3; i++) begin
            req(SPF_KIND_WRITE, ta[i], td[i]);
            `CHK(spf_dev_model_i.regs[ta[i]], td[i])
        end
        for (int i = 0; i < 3; i++) begin
            req(SPF_KIND_READ, ta[i], 8'h00);
            pop(td[i]);
        end
        $display("t_reg done");
    endtask : t_reg
    // Overfill the device store; flags must clear on their own
    task automatic t_flags();
        for (int i = 0; i < 33; i++) begin
            spf_dev_model_i.load(8'h10 + i[7:0]);
        end
        repeat (8) @(negedge i_clk);
        `CHK(o_fifo_overflow, 1'b1)
        `CHK(o_fifo_byte_written, 1'b1)
        `CHK(o_fifo_threshold, 1'b1)
        req(SPF_KIND_FIFO, 7'h00, 8'h00);
        pop(8'h10);
        `CHK(o_fifo_overflow, 1'b0)
        `CHK(o_fifo_byte_written, 1'b0)
        `CHK(o_fifo_not_empty, 1'b1)
        $display("t_flags done");
    endtask : t_flags
    // Fill the local buffer until refused, then drain the device
    task automatic t_full();
        for (int i = 1; i < 17; i++) begin
            req(SPF_KIND_FIFO, 7'h00, 8'h00);
        end
        @(negedge i_clk);
        `CHK(o_req_ready, 1'b0)
        for (int i = 1; i < 17; i++) begin
            pop(8'h10 + i[7:0]);
        end
        for (int i = 17; i < 32; i++) begin
            req(SPF_KIND_FIFO, 7'h00, 8'h00);
            pop(8'h10 + i[7:0]);
        end
        repeat (8) @(negedge i_clk);
        `CHK(o_fifo_not_empty, 1'b0)
        `CHK(o_fifo_threshold, 1'b0)
        $display("t_full done");
    endtask : t_full
    // Summary and verdict
    task conclude();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    ///////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_reg();
        t_flags();
        t_full();
        conclude();
    end
    // About 12k cycles expected; more than three times that means a hang
    initial begin
        repeat (40000) @(posedge i_clk);
        fails++;
        conclude();
    end
endmodule : tb
